/* hw/call_stack.sv */
// Hardware call stack, circular, eight entries.
// Assumes push and pop are never asserted together.
`timescale 1ns/1ps
module call_stack
  import literal_ops_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] pushValue,
  output logic [PC_W-1:0] topEntry
);
  logic [PC_W-1:0] entry_reg [STACK_DEPTH];
  logic [SP_W-1:0] ptr_reg;
  logic [SP_W-1:0] ptr_next;

  // Top is the entry below the pointer; overflow wraps silently
  assign topEntry = entry_reg[ptr_reg - SP_W'(1)];

  always_comb begin
    ptr_next = ptr_reg;
    if (push) begin
      ptr_next = ptr_reg + SP_W'(1);
    end else if (pop) begin
      ptr_next = ptr_reg - SP_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg <= '0;
    end else if (clkEn) begin
      ptr_reg <= ptr_next;
    end
  end

  genvar i;
  for (i = 0; i < STACK_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (reset) begin
        entry_reg[i] <= PC_RESET;
      end else if (clkEn && push && ptr_reg == SP_W'(i)) begin
        entry_reg[i] <= pushValue;
      end
    end
  end
endmodule : call_stack

/* hw/literal_ops.sv */
// Execution unit for return, rotate, low-power and literal instructions.
// Assumes an AHB-Lite master on clk; one file register stands in for f.
// What this block does
// (RULE1) Return-with-literal loads the literal into W; flags stay unchanged.
// (RULE2) Return-with-literal loads the program counter from the stack top.
// (RULE3) Return-with-literal takes two instruction cycles.
// (RULE4) Rotate right through carry; old carry to bit 7, bit 0 to carry.
// (RULE5) Rotate destination bit 0 writes W, 1 writes the file register.
// (RULE6) Subroutine return pops the stack into the program counter, no flags.
// (RULE7) Subroutine return takes two instruction cycles.
// (RULE8) Low-power instruction clears watchdog counter and its prescaler.
// (RULE9) Low-power sets time-out bit to 1, clears power-down bit to 0.
// (RULE10) Low-power instruction halts the oscillator until woken.
// (RULE11) Subtract-from-literal computes literal minus W; updates carry, nibble, zero.
// (RULE12) Xor-literal writes W xor literal to W; updates only Z.
// (RULE13) Zero flag means result zero; carry set means no borrow.
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module literal_ops
  import literal_ops_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic oscRun,
  output logic busy
);
  exec_state_e state_reg, state_next;
  logic [DATA_W-1:0] w_reg, w_next;
  logic [7:0] status_reg, status_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [DATA_W-1:0] file_reg, file_next;
  logic [WDOG_W-1:0] wdog_reg, wdog_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [2:0] op_reg, op_next;
  logic [31:0] operand_reg, operand_next;
  logic oscRun_reg, oscRun_next;
  logic busy_reg, busy_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic wrPend_reg, wrPend_next;
  logic [7:0] wrAddr_reg, wrAddr_next;
  logic stackPush, stackPop;
  logic [PC_W-1:0] stackTop;
  logic [DATA_W-1:0] lit;
  logic [DATA_W:0] subSum;
  logic [4:0] nibSum;
  logic [DATA_W-1:0] rotResult;
  logic addrPhase;
  logic hreadyout_reg, hresp_reg;

  function automatic logic zeroOf(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction : zeroOf

  call_stack u_stack (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .push(stackPush),
    .pop(stackPop),
    .pushValue(pc_reg),
    .topEntry(stackTop)
  );

  assign lit = operand_reg[OPR_LIT_LSB +: DATA_W];
  // Two's complement: literal + ~W + 1, carry out is the no-borrow flag
  assign subSum = {1'b0, lit} + {1'b0, ~w_reg} + 9'h001; // [RULE11] [RULE13]
  assign nibSum = {1'b0, lit[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;
  assign rotResult = {status_reg[ST_CARRY], file_reg[7:1]}; // [RULE4]
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign stackPush = state_reg == ST_EXEC && op_reg == OP_PUSH;
  assign stackPop = state_reg == ST_SECOND &&
    (op_reg == OP_RETURN || op_reg == OP_RET_LIT); // [RULE6]

  always_comb begin
    state_next = state_reg;
    w_next = w_reg;
    status_next = status_reg;
    pc_next = pc_reg;
    file_next = file_reg;
    wdog_next = wdog_reg;
    pre_next = pre_reg;
    op_next = op_reg;
    operand_next = operand_reg;
    oscRun_next = oscRun_reg;
    wrPend_next = 1'b0;
    wrAddr_next = wrAddr_reg;
    hrdata_next = hrdata_reg;
    // Watchdog stand-in counts only while the oscillator runs, so clearing is observable
    if (oscRun_reg) begin
      {wdog_next, pre_next} = {wdog_reg, pre_reg} + 16'h0001;
    end
    case (state_reg)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
        case (op_reg)
          OP_RET_LIT: begin
            w_next = lit; // [RULE1]
            state_next = ST_SECOND; // [RULE3]
          end
          OP_RETURN: begin
            state_next = ST_SECOND; // [RULE7]
          end
          OP_ROT_RIGHT: begin
            status_next[ST_CARRY] = file_reg[0]; // [RULE4]
            if (operand_reg[OPR_DEST_BIT]) begin
              file_next = rotResult; // [RULE5]
            end else begin
              w_next = rotResult; // [RULE5]
            end
          end
          OP_SLEEP: begin
            wdog_next = WDOG_CLEAR; // [RULE8]
            pre_next = PRE_CLEAR; // [RULE8]
            status_next[ST_TIMEOUT] = 1'b1; // [RULE9]
            status_next[ST_PWRDN] = 1'b0; // [RULE9]
            oscRun_next = 1'b0; // [RULE10]
            state_next = ST_ASLEEP;
          end
          OP_SUB_LIT: begin
            w_next = subSum[DATA_W-1:0]; // [RULE11]
            status_next[ST_CARRY] = subSum[DATA_W];
            status_next[ST_NIBBLE] = nibSum[4];
            status_next[ST_ZERO] = zeroOf(subSum[DATA_W-1:0]); // [RULE13]
          end
          OP_XOR_LIT: begin
            w_next = w_reg ^ lit; // [RULE12]
            status_next[ST_ZERO] = zeroOf(w_reg ^ lit); // [RULE13]
          end
          OP_PUSH: begin
            pc_next = operand_reg[OPR_PC_LSB +: PC_W];
          end
          default: begin
          end
        endcase
      end
      ST_SECOND: begin
        pc_next = stackTop; // [RULE2] [RULE6]
        state_next = ST_IDLE;
      end
      ST_ASLEEP: begin
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Bus write data phase
    if (wrPend_reg) begin
      case (wrAddr_reg)
        ADDR_CTRL: begin
          if (hwdata[CTRL_WAKE_BIT] && state_reg == ST_ASLEEP) begin
            oscRun_next = 1'b1;
            state_next = ST_IDLE;
          end else if (hwdata[CTRL_GO_BIT] && state_reg == ST_IDLE) begin
            op_next = hwdata[CTRL_OP_LSB +: 3];
            state_next = ST_EXEC;
          end
        end
        ADDR_OPERAND: operand_next = hwdata;
        ADDR_WREG: w_next = hwdata[DATA_W-1:0];
        ADDR_FILE: file_next = hwdata[DATA_W-1:0];
        ADDR_STATUS: begin
          status_next[ST_CARRY] = hwdata[ST_CARRY];
          status_next[ST_NIBBLE] = hwdata[ST_NIBBLE];
          status_next[ST_ZERO] = hwdata[ST_ZERO];
        end
        default: begin
        end
      endcase
    end
    if (addrPhase) begin
      wrPend_next = hwrite;
      wrAddr_next = haddr[7:0];
      case (haddr[7:0])
        ADDR_CTRL: hrdata_next = {29'h0, op_reg};
        ADDR_OPERAND: hrdata_next = operand_reg;
        ADDR_WREG: hrdata_next = {24'h0, w_reg};
        ADDR_STATUS: hrdata_next = {24'h0, status_reg};
        ADDR_PC: hrdata_next = {19'h0, pc_reg};
        ADDR_FILE: hrdata_next = {24'h0, file_reg};
        ADDR_WDOG: hrdata_next = {16'h0, wdog_reg, pre_reg};
        ADDR_STATE: hrdata_next = {28'h0, state_reg};
        default: hrdata_next = READ_ZERO;
      endcase
    end
  end

  assign busy_next = state_next != ST_IDLE;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      w_reg <= W_RESET;
      status_reg <= STATUS_RESET;
      pc_reg <= PC_RESET;
      file_reg <= W_RESET;
      wdog_reg <= WDOG_CLEAR;
      pre_reg <= PRE_CLEAR;
      op_reg <= OP_NONE;
      operand_reg <= READ_ZERO;
      oscRun_reg <= 1'b1;
      busy_reg <= 1'b0;
      hrdata_reg <= READ_ZERO;
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      w_reg <= w_next;
      status_reg <= status_next;
      pc_reg <= pc_next;
      file_reg <= file_next;
      wdog_reg <= wdog_next;
      pre_reg <= pre_next;
      op_reg <= op_next;
      operand_reg <= operand_next;
      oscRun_reg <= oscRun_next;
      busy_reg <= busy_next;
      hrdata_reg <= hrdata_next;
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
    end
  end

  assign hrdata = hrdata_reg;
  // No wait states and always OKAY; kept in flops so outputs stay registered
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign oscRun = oscRun_reg;
  assign busy = busy_reg;

  // Assertions
  sequence s_retStart;
    state_reg == ST_EXEC && (op_reg == OP_RET_LIT || op_reg == OP_RETURN);
  endsequence
  sequence s_retDone;
    state_reg == ST_SECOND ##1 state_reg == ST_IDLE;
  endsequence

  property p_retTwoCycle;
    @(posedge clk) disable iff (reset || !clkEn)
      s_retStart |=> s_retDone;
  endproperty
  a_retTwoCycle: assert property (p_retTwoCycle) // [RULE3] [RULE7]
    else $error("return did not finish in two cycles");

  property p_retLitW;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_EXEC && op_reg == OP_RET_LIT |=>
        w_reg == $past(lit) && status_reg == $past(status_reg);
  endproperty
  a_retLitW: assert property (p_retLitW) // [RULE1]
    else $error("return with literal wrong W or flags");

  property p_retPc;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_SECOND |=> pc_reg == $past(stackTop);
  endproperty
  a_retPc: assert property (p_retPc) // [RULE2] [RULE6]
    else $error("program counter not loaded from stack top");

  property p_rotate;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_EXEC && op_reg == OP_ROT_RIGHT |=>
        status_reg[ST_CARRY] == $past(file_reg[0]) &&
        (($past(operand_reg[OPR_DEST_BIT]) ? file_reg : w_reg) ==
         $past(rotResult));
  endproperty
  a_rotate: assert property (p_rotate) // [RULE4] [RULE5]
    else $error("rotate right result or carry wrong");

  property p_sleep;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_EXEC && op_reg == OP_SLEEP |=>
        wdog_reg == WDOG_CLEAR && pre_reg == PRE_CLEAR &&
        status_reg[ST_TIMEOUT] && !status_reg[ST_PWRDN] && !oscRun_reg;
  endproperty
  a_sleep: assert property (p_sleep) // [RULE8] [RULE9] [RULE10]
    else $error("low-power entry state wrong");

  property p_sub;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_EXEC && op_reg == OP_SUB_LIT |=>
        w_reg == 8'($past(lit) - $past(w_reg)) &&
        status_reg[ST_CARRY] == ($past(lit) >= $past(w_reg)) &&
        status_reg[ST_NIBBLE] == ($past(lit[3:0]) >= $past(w_reg[3:0])) &&
        status_reg[ST_ZERO] == (w_reg == 8'h00);
  endproperty
  a_sub: assert property (p_sub) // [RULE11] [RULE13]
    else $error("subtract from literal wrong");

  property p_xor;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_EXEC && op_reg == OP_XOR_LIT |=>
        w_reg == ($past(w_reg) ^ $past(lit)) &&
        status_reg[ST_CARRY] == $past(status_reg[ST_CARRY]) &&
        status_reg[ST_NIBBLE] == $past(status_reg[ST_NIBBLE]) &&
        status_reg[ST_ZERO] == (w_reg == 8'h00);
  endproperty
  a_xor: assert property (p_xor) // [RULE12] [RULE13]
    else $error("xor literal wrong");

  property p_sleepHold;
    @(posedge clk) disable iff (reset || !clkEn)
      state_reg == ST_ASLEEP && !wrPend_reg |=> $stable(wdog_reg);
  endproperty
  a_sleepHold: assert property (p_sleepHold) // [RULE10]
    else $error("watchdog moved while oscillator stopped");
endmodule : literal_ops

/* hw/literal_ops_pkg.sv */
// Package for the return, rotate, low-power and literal instruction unit.
// Assumes a 14-bit instruction word and a 13-bit program counter.
package literal_ops_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int WDOG_W = 8;
  localparam int PRE_W = 8;
  // Operation codes presented with a start strobe
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_RET_LIT = 3'h1;
  localparam logic [2:0] OP_ROT_RIGHT = 3'h2;
  localparam logic [2:0] OP_RETURN = 3'h3;
  localparam logic [2:0] OP_SLEEP = 3'h4;
  localparam logic [2:0] OP_SUB_LIT = 3'h5;
  localparam logic [2:0] OP_XOR_LIT = 3'h6;
  localparam logic [2:0] OP_PUSH = 3'h7;
  // Status register bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [WDOG_W-1:0] WDOG_CLEAR = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  // Register bus offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_WREG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_FILE = 8'h14;
  localparam logic [7:0] ADDR_WDOG = 8'h18;
  localparam logic [7:0] ADDR_STATE = 8'h1C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 4;
  localparam int CTRL_WAKE_BIT = 5;
  localparam int OPR_LIT_LSB = 0;
  localparam int OPR_FA_LSB = 8;
  localparam int OPR_DEST_BIT = 15;
  localparam int OPR_PC_LSB = 16;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_SECOND = 4'h4,
    ST_ASLEEP = 4'h8
  } exec_state_e;
endpackage : literal_ops_pkg

/* tb/test_literal_ops.sv */
// Self-checking bench for the literal_ops execution unit.
// Assumes a lone AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module test_literal_ops;
  import literal_ops_pkg::*;
  typedef struct {logic [31:0] val; string name;} expect_s;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, oscRun, busy;
  logic rdPhase = 1'b0;
  logic [7:0] statusHigh = STATUS_RESET;
  logic [7:0] f, w, k, r;
  logic [2:0] fl;
  logic [12:0] v1, v2;
  expect_s expQ[$];
  expect_s seen;
  int mismatches = 0;
  int checksDone = 0;
  int cycles = 0;
  int seed = 32360;

  always #5 clk = ~clk;

  literal_ops dut (.clk(clk), .reset(reset), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .oscRun(oscRun), .busy(busy));

  task automatic checkVal(input string name, input logic [31:0] exp,
                          input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : checkVal

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finalReport

  // Read data is judged only in its data phase, against the oldest note
  always @(posedge clk) begin
    if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
      seen = expQ.pop_front();
      checkVal(seen.name, seen.val, hrdata);
      checkVal("hresp", 32'h0, {31'h0, hresp});
    end
    rdPhase <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      finalReport();
    end
  end

  function automatic logic [7:0] rnd8();
    int t;
    t = $random(seed);
    return t[7:0];
  endfunction : rnd8

  function automatic logic [31:0] st(input logic z, input logic dc,
                                     input logic c);
    return {24'h000000, statusHigh[7:3], z, dc, c};
  endfunction : st

  // One single transfer; the address phase is held until hready is seen
  task automatic busXfer(input logic wr, input logic [7:0] addr,
                         input logic [31:0] data);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    // Only the bench timeout ends a wait for hready
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= data;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
  endtask : busXfer

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp,
                    input string name);
    expQ.push_back('{exp, name});
    busXfer(1'b0, addr, 32'h00000000);
  endtask : rd

  // Counts the cycles busy stays up; zero cycles means wait only
  task automatic runOp(input logic [2:0] op, input logic [31:0] operand,
                       input int expCycles);
    int n;
    busXfer(1'b1, ADDR_OPERAND, operand);
    busXfer(1'b1, ADDR_CTRL, (32'h1 << CTRL_GO_BIT) | {29'h0, op});
    n = 0;
    #1;
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
      #1;
    end
    if (expCycles > 0) begin
      checkVal("busy cycles", expCycles, n);
    end
  endtask : runOp

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_WREG, 32'h00000000, "w reset");
    rd(ADDR_STATUS, 32'h00000018, "status reset");
    rd(ADDR_PC, 32'h00000000, "pc reset");
    rd(ADDR_STATE, 32'h00000001, "state reset");
    rd(8'h40, 32'h00000000, "unmapped read");
    checkVal("osc reset", 32'h1, {31'h0, oscRun});
    v1 = 13'({rnd8(), rnd8()});
    v2 = 13'({rnd8(), rnd8()});
    runOp(OP_PUSH, {3'h0, v1, 16'h0000}, 0);
    runOp(OP_PUSH, {3'h0, v2, 16'h0000}, 0);
    rd(ADDR_PC, {19'h0, v2}, "pc after push");
    busXfer(1'b1, ADDR_STATUS, 32'h00000007);
    runOp(OP_RETURN, 32'h00000000, 2);
    rd(ADDR_PC, {19'h0, v1}, "pc return");
    rd(ADDR_STATUS, 32'h0000001F, "status return");
    k = rnd8();
    runOp(OP_RET_LIT, {24'h0, k}, 2);
    rd(ADDR_PC, 32'h00000000, "pc ret lit");
    rd(ADDR_WREG, {24'h0, k}, "w ret lit");
    rd(ADDR_STATUS, 32'h0000001F, "status ret lit");
    // Every destination and carry-in pairing
    for (int i = 0; i < 4; i++) begin
      f = rnd8();
      w = rnd8();
      fl = 3'({rnd8() % 8'h04, i[0]});
      r = {fl[0], f[7:1]};
      busXfer(1'b1, ADDR_FILE, {24'h0, f});
      busXfer(1'b1, ADDR_WREG, {24'h0, w});
      busXfer(1'b1, ADDR_STATUS, {29'h0, fl});
      runOp(OP_ROT_RIGHT, {16'h0, i[1], 7'(rnd8() % 8'h80), 8'h00},
            0);
      rd(ADDR_WREG, {24'h0, i[1] ? w : r}, "w rotate");
      rd(ADDR_FILE, {24'h0, i[1] ? r : f}, "file rotate");
      rd(ADDR_STATUS, st(fl[2], fl[1], f[0]), "status rotate");
    end
    // Random pairs, then equal, zero W and borrow cases
    for (int i = 0; i < 6; i++) begin
      k = rnd8();
      w = (i == 3) ? k : (i == 4) ? 8'h00 : rnd8();
      if (i == 5) begin
        k = 8'h00;
        w = 8'h01;
      end
      r = k - w;
      busXfer(1'b1, ADDR_WREG, {24'h0, w});
      runOp(OP_SUB_LIT, {24'h0, k}, 0);
      rd(ADDR_WREG, {24'h0, r}, "w subtract");
      rd(ADDR_STATUS, st(r == 8'h00, k[3:0] >= w[3:0], k >= w),
         "status subtract");
    end
    for (int i = 0; i < 4; i++) begin
      w = rnd8();
      k = (i == 3) ? w : rnd8();
      fl = 3'(rnd8() % 8'h08);
      r = w ^ k;
      busXfer(1'b1, ADDR_WREG, {24'h0, w});
      busXfer(1'b1, ADDR_STATUS, {29'h0, fl});
      runOp(OP_XOR_LIT, {24'h0, k}, 0);
      rd(ADDR_WREG, {24'h0, r}, "w xor");
      rd(ADDR_STATUS, st(r == 8'h00, fl[1], fl[0]), "status xor");
    end
    // Sleep goes last: the unit stays asleep until the bench writes the wake bit to ADDR_CTRL
    busXfer(1'b1, ADDR_STATUS, 32'h00000000);
    busXfer(1'b1, ADDR_OPERAND, 32'h00000000);
    busXfer(1'b1, ADDR_CTRL, (32'h1 << CTRL_GO_BIT) | {29'h0, OP_SLEEP});
    repeat (3) @(posedge clk);
    checkVal("osc asleep", 32'h0, {31'h0, oscRun});
    statusHigh = 8'h10;
    rd(ADDR_STATUS, st(1'b0, 1'b0, 1'b0), "status sleep");
    rd(ADDR_WDOG, 32'h00000000, "watchdog sleep");
    rd(ADDR_STATE, 32'h00000008, "state sleep");
    repeat (20) @(posedge clk);
    rd(ADDR_WDOG, 32'h00000000, "watchdog halted");
    busXfer(1'b1, ADDR_CTRL, 32'h1 << CTRL_WAKE_BIT);
    rd(ADDR_STATE, 32'h00000001, "state woken");
    checkVal("osc woken", 32'h1, {31'h0, oscRun});
    repeat (2) @(posedge clk);
    finalReport();
  end
endmodule : test_literal_ops
